/* File: rtl/serial_position_transmitter.v */
`timescale 1ns/1ps
`include "serial_position_defines.vh"
module serial_position_transmitter (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [23:0] i_position,
  input wire i_addressable,
  input wire [3:0] i_baud_switch,
  input wire [3:0] i_address_switch,
  input wire [3:0] i_mode_switch,
  input wire i_rx,
  output reg o_tx,
  output reg o_busy,
  output reg o_auto_mode
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_LOAD = 4'b0010;
  localparam ST_SEND = 4'b0100;
  localparam ST_GAP = 4'b1000;

  function [31:0] baud_of;
    input [2:0] sel;
    begin
      case (sel)
        3'd0: baud_of = `BAUD_9600;
        3'd1: baud_of = `BAUD_600;
        3'd2: baud_of = `BAUD_1200;
        3'd3: baud_of = `BAUD_2400;
        3'd4: baud_of = `BAUD_4800;
        3'd5: baud_of = `BAUD_19200;
        3'd6: baud_of = `BAUD_38400;
        default: baud_of = `BAUD_115200;
      endcase
    end
  endfunction

  function [17:0] div_of;
    input [2:0] sel;
    reg [31:0] q;
    begin
      q = `CLK_HZ / baud_of(sel);
      div_of = q[17:0];
    end
  endfunction

  // Plain baud select
  // Switch 0-7 on plain variant is undefined; mapped like 8-F.
  wire [2:0] plain_sel = i_baud_switch[2:0];
  wire [2:0] baud_sel = i_addressable ? i_mode_switch[2:0] : plain_sel;
  wire auto = ~i_addressable | i_mode_switch[3];
  wire [7:0] own_addr = `ADDR_BASE + {4'h0, i_address_switch};

  reg [17:0] bit_div;
  reg [17:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_shift;
  reg [3:0] state;
  reg [2:0] msg_idx;
  reg [2:0] msg_len;
  reg [1:0] msg_kind;
  reg [7:0] err_code;
  reg [23:0] pos_latch;
  reg [3:0] gap_cnt;
  reg [7:0] cur_byte;

  // Receiver state
  reg [1:0] rx_sync;
  reg [17:0] rx_cnt;
  reg [3:0] rx_bit;
  reg [7:0] rx_shift;
  reg rx_active;
  reg [2:0] req_idx;
  reg [7:0] req_cmd;
  reg [7:0] req_addr;
  reg [7:0] req_chk;
  reg req_bad;
  reg req_pending;
  reg [1:0] req_kind;
  reg [7:0] req_err;

  always @* begin
    cur_byte = `BYTE_START;
    case (msg_kind)
      2'd0: begin
        case (msg_idx)
          3'd1: cur_byte = pos_latch[23:16];
          3'd2: cur_byte = pos_latch[15:8];
          3'd3: cur_byte = pos_latch[7:0];
          3'd4: cur_byte = `BYTE_END;
          3'd5: cur_byte = `BYTE_NUL;
          3'd6: cur_byte = `BYTE_CR;
          default: cur_byte = `BYTE_START;
        endcase
      end
      2'd1: begin
        case (msg_idx)
          3'd1: cur_byte = pos_latch[23:16];
          3'd2: cur_byte = pos_latch[15:8];
          3'd3: cur_byte = pos_latch[7:0];
          3'd4: cur_byte = own_addr;
          default: cur_byte = `BYTE_START;
        endcase
      end
      default: begin
        case (msg_idx)
          3'd1: cur_byte = `BYTE_ERR_MARK;
          3'd2: cur_byte = `BYTE_ERR_MARK;
          3'd3: cur_byte = err_code;
          3'd4: cur_byte = `BYTE_END;
          default: cur_byte = `BYTE_START;
        endcase
      end
    endcase
  end

  wire rx_mid = rx_active && (rx_cnt == {1'b0, bit_div[17:1]});
  wire rx_in = rx_sync[1];
  wire [7:0] chk_sum = `BYTE_START + req_cmd + req_addr;
  // Clear and take in one cycle, so a request ending then is kept
  wire take_now = (state == ST_IDLE) && !auto && req_pending;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_sync <= 2'b11;
      rx_cnt <= 18'd0;
      rx_bit <= 4'd0;
      rx_shift <= 8'h00;
      rx_active <= 1'b0;
      req_idx <= 3'd0;
      req_cmd <= 8'h00;
      req_addr <= 8'h00;
      req_chk <= 8'h00;
      req_bad <= 1'b0;
      req_pending <= 1'b0;
      req_kind <= 2'd0;
      req_err <= 8'h00;
    end else begin
      rx_sync <= {rx_sync[0], i_rx};
      // Set after clear: a request finished in the take cycle wins
      if (take_now)
        req_pending <= 1'b0;
      if (!rx_active) begin
        if (!rx_in) begin
          rx_active <= 1'b1;
          rx_cnt <= 18'd0;
          rx_bit <= 4'd0;
        end
      end else if (rx_cnt == bit_div - 18'd1) begin
        rx_cnt <= 18'd0;
      end else begin
        rx_cnt <= rx_cnt + 18'd1;
      end
      if (rx_mid) begin
        rx_bit <= rx_bit + 4'd1;
        if (rx_bit == 4'd0 && rx_in)
          rx_active <= 1'b0;
        else if (rx_bit >= 4'd1 && rx_bit <= 4'd8)
          rx_shift <= {rx_in, rx_shift[7:1]};
        else if (rx_bit == 4'd9) begin
          rx_active <= 1'b0;
          case (req_idx)
            3'd0: if (rx_shift == `BYTE_START) begin
              req_idx <= 3'd1;
              req_bad <= 1'b0;
            end
            3'd1: begin
              req_cmd <= rx_shift;
              req_idx <= 3'd2;
              if (rx_shift != `CMD_POSITION)
                req_bad <= 1'b1;
            end
            3'd2: begin
              req_addr <= rx_shift;
              req_idx <= 3'd3;
            end
            3'd3: begin
              req_chk <= rx_shift;
              req_idx <= 3'd4;
            end
            default: begin
              req_idx <= 3'd0;
              if (!auto) begin
                if (req_bad || rx_shift != `BYTE_END) begin
                  req_pending <= 1'b1;
                  req_kind <= 2'd2;
                  req_err <= `ERR_SEQUENCE;
                end else if (req_chk != chk_sum) begin
                  req_pending <= 1'b1;
                  req_kind <= 2'd2;
                  req_err <= `ERR_CHECKSUM;
                end else if (req_addr == own_addr) begin
                  req_pending <= 1'b1;
                  req_kind <= 2'd1;
                end
              end
            end
          endcase
        end
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      bit_div <= div_of(3'd0);
      tx_cnt <= 18'd0;
      tx_bit <= 4'd0;
      tx_shift <= 10'h3FF;
      state <= ST_IDLE;
      msg_idx <= 3'd0;
      msg_len <= 3'd6;
      msg_kind <= 2'd0;
      err_code <= 8'h00;
      pos_latch <= 24'h00_0000;
      gap_cnt <= 4'h0;
      o_tx <= 1'b1;
      o_busy <= 1'b0;
      o_auto_mode <= 1'b0;
    end else begin
      o_auto_mode <= auto;
      case (state)
        ST_IDLE: begin
          o_busy <= 1'b0;
          o_tx <= 1'b1;
          // Rate only changes between messages to avoid torn frames
          bit_div <= div_of(baud_sel);
          msg_idx <= 3'd0;
          if (auto) begin
            msg_kind <= 2'd0;
            msg_len <= 3'd6;
            pos_latch <= i_position;
            state <= ST_LOAD;
          end else if (take_now) begin
            msg_kind <= req_kind;
            msg_len <= 3'd4;
            err_code <= req_err;
            pos_latch <= i_position;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          o_busy <= 1'b1;
          tx_shift <= {1'b1, cur_byte, 1'b0};
          tx_cnt <= 18'd0;
          tx_bit <= 4'd0;
          state <= ST_SEND;
        end
        ST_SEND: begin
          o_tx <= tx_shift[0];
          if (tx_cnt == bit_div - 18'd1) begin
            tx_cnt <= 18'd0;
            tx_shift <= {1'b1, tx_shift[9:1]};
            if (tx_bit == 4'd9) begin
              if (msg_idx == msg_len) begin
                gap_cnt <= `AUTO_GAP_BYTES;
                state <= ST_GAP;
              end else begin
                msg_idx <= msg_idx + 3'd1;
                state <= ST_LOAD;
              end
            end else begin
              tx_bit <= tx_bit + 4'd1;
            end
          end else begin
            tx_cnt <= tx_cnt + 18'd1;
          end
        end
        ST_GAP: begin
          o_tx <= 1'b1;
          if (tx_cnt == bit_div - 18'd1) begin
            tx_cnt <= 18'd0;
            gap_cnt <= gap_cnt - 4'h1;
            if (gap_cnt == 4'h1)
              state <= ST_IDLE;
          end else begin
            tx_cnt <= tx_cnt + 18'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // serial_position_transmitter

/* File: rtl/serial_position_defines.vh */
`ifndef SERIAL_POSITION_DEFINES_VH
`define SERIAL_POSITION_DEFINES_VH
`define CLK_HZ 100000000
`define BYTE_START 8'h02
`define BYTE_END 8'h03
`define BYTE_NUL 8'h00
`define BYTE_CR 8'h0D
`define BYTE_ERR_MARK 8'hFF
`define CMD_POSITION 8'h04
`define ADDR_BASE 8'h0B
`define ERR_SEQUENCE 8'h04
`define ERR_CHECKSUM 8'h0A
`define DATA_BITS 8
`define BAUD_9600 9600
`define BAUD_600 600
`define BAUD_1200 1200
`define BAUD_2400 2400
`define BAUD_4800 4800
`define BAUD_19200 19200
`define BAUD_38400 38400
`define BAUD_115200 115200
`define AUTO_GAP_BYTES 4'h1
`endif

/* File: bench/serial_position_asserts.sv */
`timescale 1ns/1ps
module serial_position_asserts (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_addressable,
  input wire [3:0] i_mode_switch,
  input wire i_rx,
  input wire o_tx,
  input wire o_busy,
  input wire o_auto_mode
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_rst_line; $fell(i_rst) |-> o_tx && !o_busy; endproperty
  a_rst_line: assert property (p_rst_line)
    else $error("line not idle after reset");
  property p_rst_mode; $fell(i_rst) |-> !o_auto_mode; endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("auto mode set during reset");
  property p_mode;
    1'b1 |=> o_auto_mode == $past(!i_addressable || i_mode_switch[3]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("auto mode does not follow switch");
  property p_idle; !o_busy |-> o_tx; endproperty
  a_idle: assert property (p_idle)
    else $error("line low while idle");
  property p_start; $rose(o_busy) |=> !o_tx; endproperty
  a_start: assert property (p_start)
    else $error("no start bit after load");
  property p_end; $fell(o_busy) |-> o_tx; endproperty
  a_end: assert property (p_end)
    else $error("message ends without stop level");
  property p_hold; $rose(o_busy) |-> o_busy [*8]; endproperty
  a_hold: assert property (p_hold)
    else $error("busy dropped right after start");
  // Answer only once the request stop level is seen
  property p_poll;
    !o_auto_mode && $rose(o_busy) |-> i_rx && $past(i_rx, 2);
  endproperty
  a_poll: assert property (p_poll)
    else $error("answer started inside a request");
endmodule // serial_position_asserts

/* File: bench/serial_master.sv */
`timescale 1ns/1ps
module serial_master #(
  parameter integer bit_div = 868
) (
  input wire i_clk_sys,
  input wire i_line,
  output reg o_line
);
  initial o_line = 1'b1;
  // Automatic: sender and receiver wait at the same time
  task automatic wait_cycles(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) @(posedge i_clk_sys);
    end
  endtask
  // Start, eight bits LSB first, stop
  task automatic send_byte(input [7:0] b);
    integer k;
    begin
      for (k = 0; k < 10; k = k + 1) begin
        o_line <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k - 1];
        wait_cycles(bit_div);
      end
    end
  endtask
  // Mid-bit sampling, framing faults invert the byte
  task automatic recv_byte(output [7:0] b);
    integer k;
    reg ok;
    begin
      while (i_line !== 1'b0) @(posedge i_clk_sys);
      wait_cycles(bit_div / 2);
      ok = (i_line === 1'b0);
      for (k = 0; k < 8; k = k + 1) begin
        wait_cycles(bit_div);
        b[k] = i_line;
      end
      wait_cycles(bit_div);
      if (!ok || i_line !== 1'b1) b = ~b;
    end
  endtask
  // Poll frame with summed check byte
  task send_poll(input [7:0] addr);
    begin
      send_byte(8'h02);
      send_byte(8'h04);
      send_byte(addr);
      send_byte(8'h02 + 8'h04 + addr);
      send_byte(8'h03);
    end
  endtask
endmodule // serial_master

/* File: bench/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) cmp(g, e)
module tb;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [23:0] position = 24'h00_0000;
  reg addressable = 1'b0;
  reg [3:0] baud_switch = 4'hF;
  reg [3:0] address_switch = 4'h0;
  reg [3:0] mode_switch = 4'h0;
  wire rx;
  wire tx;
  wire busy;
  wire auto_mode;
  integer miscompares = 0;
  integer checked = 0;
  reg [7:0] got [0:6];
  integer k;
  serial_position_transmitter uut (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_position(position),
    .i_addressable(addressable), .i_baud_switch(baud_switch),
    .i_address_switch(address_switch), .i_mode_switch(mode_switch),
    .i_rx(rx), .o_tx(tx), .o_busy(busy), .o_auto_mode(auto_mode)
  );
  // Fastest rate keeps the run short; 100e6 / 115200 cycles a bit
  serial_master #(.bit_div(868)) m (
    .i_clk_sys(clk_sys), .i_line(tx), .o_line(rx)
  );
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task cmp(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task final_report;
    begin
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task do_reset;
    begin
      rst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
    end
  endtask
  task auto_frame;
    begin
      addressable <= 1'b0;
      baud_switch <= 4'hF;
      position <= 24'h5A_C3E1;
      do_reset;
      for (k = 0; k < 7; k = k + 1) m.recv_byte(got[k]);
      `CHK({7'h00, auto_mode}, 8'h01);
      `CHK(got[0], 8'h02);
      `CHK(got[1], 8'h5A);
      `CHK(got[2], 8'hC3);
      `CHK(got[3], 8'hE1);
      `CHK(got[4], 8'h03);
      `CHK(got[5], 8'h00);
      `CHK(got[6], 8'h0D);
    end
  endtask
  // Second reset mid-run, then a poll to the highest switch address
  task poll_answer;
    begin
      addressable <= 1'b1;
      mode_switch <= 4'h7;
      address_switch <= 4'hF;
      position <= 24'h0F_00A5;
      do_reset;
      repeat (3) @(posedge clk_sys);
      `CHK({7'h00, auto_mode}, 8'h00);
      fork
        m.send_poll(8'h1A);
        for (k = 0; k < 5; k = k + 1) m.recv_byte(got[k]);
      join
      `CHK(got[0], 8'h02);
      `CHK(got[1], 8'h0F);
      `CHK(got[2], 8'h00);
      `CHK(got[3], 8'hA5);
      `CHK(got[4], 8'h1A);
    end
  endtask
  // Own address but check byte off by one
  task poll_bad_check;
    begin
      fork
        begin
          m.send_byte(8'h02);
          m.send_byte(8'h04);
          m.send_byte(8'h1A);
          m.send_byte(8'h21);
          m.send_byte(8'h03);
        end
        for (k = 0; k < 5; k = k + 1) m.recv_byte(got[k]);
      join
      `CHK(got[0], 8'h02);
      `CHK(got[1], 8'hFF);
      `CHK(got[2], 8'hFF);
      `CHK(got[3], 8'h0A);
      `CHK(got[4], 8'h03);
    end
  endtask
  initial begin
    @(posedge clk_sys);
    auto_frame;
    poll_answer;
    poll_bad_check;
    final_report;
  end
  // All scenarios need about 240k cycles
  initial begin
    #3_000_000;
    miscompares = miscompares + 1;
    final_report;
  end
endmodule // tb
bind serial_position_transmitter serial_position_asserts chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rx(i_rx),
  .i_addressable(i_addressable), .i_mode_switch(i_mode_switch),
  .o_tx(o_tx), .o_busy(o_busy), .o_auto_mode(o_auto_mode)
);
